/* rtl/ad_defines.vh */
`ifndef AD_DEFINES_VH
`define AD_DEFINES_VH

// ==========================================================
// Control word layout
`define AD_DIR_BIT 15
`define AD_IDX_HI 14
`define AD_IDX_LO 8
`define AD_DIR_WRITE 1'b0
`define AD_DIR_READ 1'b1

// ==========================================================
// Register indices
`define AD_REG_OUTDIS 7'h08
`define AD_REG_FMT 7'h09
`define AD_REG_DEEMPH 7'h0a
`define AD_REG_RDBACK 7'h0b
`define AD_REG_FIRST 7'h01

// ==========================================================
// Output disable register
`define AD_OUTDIS_HI 5
`define AD_OUTDIS_LO 0
`define AD_OUTDIS_RST 6'h00

// ==========================================================
// Format, clock and filter register
`define AD_FLT_BIT 5
`define AD_FLT_RST 1'h0
`define AD_CLOCK_OUT_HALF_RATE_BIT 4
`define AD_CLOCK_OUT_HALF_RATE_RST 1'h0
`define AD_CLOCK_OUT_DISABLE_BIT 3
`define AD_CLOCK_OUT_DISABLE_RST 1'h0
`define AD_FMT_HI 2
`define AD_FMT_LO 0
`define AD_FMT_RST 3'h0
`define AD_FMT_RJ24 3'h0
`define AD_FMT_RJ20 3'h1
`define AD_FMT_RJ18 3'h2
`define AD_FMT_RJ16 3'h3
`define AD_FMT_I2S 3'h4
`define AD_FMT_LJ 3'h5

// ==========================================================
// De-emphasis register
`define AD_DMF_HI 4
`define AD_DMF_LO 3
`define AD_DMF_RST 2'h0
`define AD_DMF_44K1 2'h0
`define AD_DMF_48K 2'h1
`define AD_DMF_32K 2'h2
`define AD_DM_HI 2
`define AD_DM_LO 0
`define AD_DM_RST 3'h0

// ==========================================================
// Readback register
`define AD_INC_BIT 7
`define AD_INC_RST 1'h0
`define AD_RIDX_HI 6
`define AD_RIDX_LO 0
`define AD_RIDX_RST 7'h01

`endif

/* rtl/ad_field.v */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// One writable control field with its own reset value
module ad_field #(
   parameter W = 1,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   input wire mclk, // System clock
   input wire srst, // Synchronous reset
   input wire we, // Write strobe
   input wire [W-1:0] d, // Write data
   output reg [W-1:0] q // Stored value
);

   always @(posedge mclk) begin
      if (srst) begin
         q <= RST;
      end else if (we) begin
         q <= d;
      end
   end

endmodule

`default_nettype wire

/* rtl/ad_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "ad_defines.vh"

module ad_ctrl (
   input wire mclk, // System clock, 100 MHz
   input wire srst, // Synchronous reset, high
   input wire ctl_valid, // Control word strobe
   input wire [15:0] ctl_word, // Control word
   output reg ctl_busy, // Readback burst running
   output reg rd_valid, // Readback word strobe
   output reg rd_last, // Last word of a readback
   output reg [15:0] rd_word, // Readback word
   input wire system_clock_input_pin, // Clock to forward
   output reg system_clock_output_pin_o, // Clock out value
   output reg system_clock_output_pin_oe, // Clock out enable
   output reg [5:0] amp_from_common_mode, // Amp input select
   output wire [5:0] channel_output_disable, // Disable bits
   output wire filter_rolloff_select, // Slow roll-off
   output wire clock_out_half_rate, // Half rate clock
   output wire clock_out_disable, // Clock pin off
   output wire [2:0] audio_format_select, // Audio format
   output wire [1:0] deemph_rate_select, // De-emph rate
   output wire deemph_enable_pair_a, // De-emph ch 1, 2
   output wire deemph_enable_pair_b, // De-emph ch 3, 4
   output wire deemph_enable_pair_c, // De-emph ch 5, 6
   output wire readback_auto_inc, // Auto-increment
   output wire [6:0] readback_index // Read index
);

   // =======================================================
   // States
   localparam ST_IDLE = 1'b0;
   localparam ST_BURST = 1'b1;

   // =======================================================
   // Control word decode
   wire is_write;
   wire is_read;
   wire [6:0] word_register_index;
   wire [7:0] wdata;
   wire we_outdis;
   wire we_fmt;
   wire we_deemph;
   wire we_rdback;

   assign word_register_index =
      ctl_word[`AD_IDX_HI:`AD_IDX_LO];
   assign is_write = ctl_valid &
      (ctl_word[`AD_DIR_BIT] == `AD_DIR_WRITE);
   assign is_read = ctl_valid &
      (ctl_word[`AD_DIR_BIT] == `AD_DIR_READ);
   assign wdata = ctl_word[7:0];
   assign we_outdis = is_write &
      (word_register_index == `AD_REG_OUTDIS);
   assign we_fmt = is_write &
      (word_register_index == `AD_REG_FMT);
   assign we_deemph = is_write &
      (word_register_index == `AD_REG_DEEMPH);
   assign we_rdback = is_write &
      (word_register_index == `AD_REG_RDBACK);

   // =======================================================
   // Register fields; reserved bits have no storage
   ad_field #(
      .W(6),
      .RST(`AD_OUTDIS_RST)
   ) u_outdis (
      .mclk(mclk),
      .srst(srst),
      .we(we_outdis),
      .d(wdata[`AD_OUTDIS_HI:`AD_OUTDIS_LO]),
      .q(channel_output_disable)
   );

   ad_field #(
      .W(1),
      .RST(`AD_FLT_RST)
   ) u_flt (
      .mclk(mclk),
      .srst(srst),
      .we(we_fmt),
      .d(wdata[`AD_FLT_BIT]),
      .q(filter_rolloff_select)
   );

   ad_field #(
      .W(1),
      .RST(`AD_CLOCK_OUT_HALF_RATE_RST)
   ) u_clock_out_half_rate (
      .mclk(mclk),
      .srst(srst),
      .we(we_fmt),
      .d(wdata[`AD_CLOCK_OUT_HALF_RATE_BIT]),
      .q(clock_out_half_rate)
   );

   ad_field #(
      .W(1),
      .RST(`AD_CLOCK_OUT_DISABLE_RST)
   ) u_clock_out_disable (
      .mclk(mclk),
      .srst(srst),
      .we(we_fmt),
      .d(wdata[`AD_CLOCK_OUT_DISABLE_BIT]),
      .q(clock_out_disable)
   );

   ad_field #(
      .W(3),
      .RST(`AD_FMT_RST)
   ) u_fmt (
      .mclk(mclk),
      .srst(srst),
      .we(we_fmt),
      .d(wdata[`AD_FMT_HI:`AD_FMT_LO]),
      .q(audio_format_select)
   );

   ad_field #(
      .W(2),
      .RST(`AD_DMF_RST)
   ) u_dmf (
      .mclk(mclk),
      .srst(srst),
      .we(we_deemph),
      .d(wdata[`AD_DMF_HI:`AD_DMF_LO]),
      .q(deemph_rate_select)
   );

   wire [2:0] deemph_en;

   ad_field #(
      .W(3),
      .RST(`AD_DM_RST)
   ) u_dm (
      .mclk(mclk),
      .srst(srst),
      .we(we_deemph),
      .d(wdata[`AD_DM_HI:`AD_DM_LO]),
      .q(deemph_en)
   );

   assign deemph_enable_pair_a = deemph_en[0];
   assign deemph_enable_pair_b = deemph_en[1];
   assign deemph_enable_pair_c = deemph_en[2];

   ad_field #(
      .W(1),
      .RST(`AD_INC_RST)
   ) u_inc (
      .mclk(mclk),
      .srst(srst),
      .we(we_rdback),
      .d(wdata[`AD_INC_BIT]),
      .q(readback_auto_inc)
   );

   ad_field #(
      .W(7),
      .RST(`AD_RIDX_RST)
   ) u_ridx (
      .mclk(mclk),
      .srst(srst),
      .we(we_rdback),
      .d(wdata[`AD_RIDX_HI:`AD_RIDX_LO]),
      .q(readback_index)
   );

   // =======================================================
   // Read data of one register, zero where unmapped
   function [7:0] reg_byte;
      input [6:0] idx;
      begin
         reg_byte = 8'h00;
         case (idx)
            `AD_REG_OUTDIS: begin
               reg_byte = {2'h0, channel_output_disable};
            end
            `AD_REG_FMT: begin
               reg_byte = {2'h0, filter_rolloff_select,
                  clock_out_half_rate, clock_out_disable,
                  audio_format_select};
            end
            `AD_REG_DEEMPH: begin
               reg_byte = {3'h0, deemph_rate_select,
                  deemph_en};
            end
            `AD_REG_RDBACK: begin
               reg_byte = {readback_auto_inc,
                  readback_index};
            end
            default: begin
               reg_byte = 8'h00;
            end
         endcase
      end
   endfunction

   // =======================================================
   // Readback sequencer
   reg state;
   reg [6:0] cur_idx;
   reg [6:0] last_idx;
   wire burst_end;

   assign burst_end = (cur_idx >= last_idx);

   always @(posedge mclk) begin
      if (srst) begin
         state <= ST_IDLE;
         cur_idx <= 7'h00;
         last_idx <= 7'h00;
         ctl_busy <= 1'b0;
         rd_valid <= 1'b0;
         rd_last <= 1'b0;
         rd_word <= 16'h0000;
      end else begin
         rd_valid <= 1'b0;
         rd_last <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (is_read && !readback_auto_inc) begin
                  rd_valid <= 1'b1;
                  rd_last <= 1'b1;
                  rd_word <= {1'b0, readback_index,
                     reg_byte(readback_index)};
               end else if (is_read) begin
                  // Sequence runs from register 1 upward
                  cur_idx <= `AD_REG_FIRST;
                  last_idx <= readback_index;
                  ctl_busy <= 1'b1;
                  state <= ST_BURST;
               end
            end
            ST_BURST: begin
               rd_valid <= 1'b1;
               rd_word <= {1'b0, cur_idx, reg_byte(cur_idx)};
               cur_idx <= cur_idx + 7'h01;
               if (burst_end) begin
                  rd_last <= 1'b1;
                  ctl_busy <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // =======================================================
   // Amplifier input select per channel
   always @(posedge mclk) begin
      if (srst) begin
         amp_from_common_mode <= 6'h00;
      end else begin
         amp_from_common_mode <= channel_output_disable;
      end
   end

   // =======================================================
   // Clock output pin: full rate copy or half rate toggle
   reg clk_in_prev;
   reg half_clk;

   always @(posedge mclk) begin
      if (srst) begin
         clk_in_prev <= 1'b0;
         half_clk <= 1'b0;
         system_clock_output_pin_o <= 1'b0;
         system_clock_output_pin_oe <= 1'b0;
      end else begin
         clk_in_prev <= system_clock_input_pin;
         if (system_clock_input_pin && !clk_in_prev) begin
            half_clk <= ~half_clk;
         end
         if (clock_out_half_rate) begin
            system_clock_output_pin_o <= half_clk;
         end else begin
            system_clock_output_pin_o <= system_clock_input_pin;
         end
         system_clock_output_pin_oe <= ~clock_out_disable;
      end
   end

endmodule

`default_nettype wire

/* verification/ad_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host side of the control port
module ad_host (
   input wire logic mclk, // Clock
   output logic ctl_valid, // Strobe
   output logic [15:0] ctl_word // Word
);
   initial begin
      ctl_valid = 1'b0;
      ctl_word = 16'h0000;
   end
   // Held until the taking edge, then scrambled so stale data never helps
   task automatic put(input logic [15:0] w);
      @(posedge mclk);
      #1;
      ctl_valid = 1'b1;
      ctl_word = w;
      @(posedge mclk);
      #1;
      ctl_valid = 1'b0;
      ctl_word = ~w;
   endtask
endmodule
`default_nettype wire

/* verification/ad_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker
module ad_chk (
   input wire logic mclk, // Clock
   input wire logic srst, // Reset
   input wire logic ctl_valid, // Strobe
   input wire logic [15:0] ctl_word, // Word
   input wire logic ctl_busy, // Busy
   input wire logic rd_valid, // Read strobe
   input wire logic rd_last, // Last word
   input wire logic system_clock_output_pin_oe, // Pin enable
   input wire logic [5:0] amp_from_common_mode, // Amp select
   input wire logic [5:0] channel_output_disable, // Disables
   input wire logic clock_out_disable, // Pin off
   input wire logic [2:0] audio_format_select, // Format
   input wire logic readback_auto_inc, // Auto inc
   input wire logic [6:0] readback_index // Index
);
   wire logic wr = ctl_valid && !ctl_word[15];
   wire logic rq = ctl_valid && ctl_word[15] && !ctl_busy;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   a_amp_follow: assert property (
      amp_from_common_mode == $past(channel_output_disable))
      else $error("amp select lag");
   a_outdis_write: assert property (
      (wr && ctl_word[14:8] == 7'h08) |=>
      channel_output_disable == $past(ctl_word[5:0]))
      else $error("output disable write");
   a_format_write: assert property (
      (wr && ctl_word[14:8] == 7'h09) |=>
      audio_format_select == $past(ctl_word[2:0]))
      else $error("format write");
   a_pin_enable: assert property (
      !$past(srst) |->
      system_clock_output_pin_oe == !$past(clock_out_disable))
      else $error("clock pin enable");
   a_readback_write: assert property (
      (wr && ctl_word[14:8] == 7'h0b) |=>
      {readback_auto_inc, readback_index} == $past(ctl_word[7:0]))
      else $error("readback write");
   a_reset_value: assert property (
      $past(srst) |-> readback_index == 7'h01 && !readback_auto_inc
      && audio_format_select == 3'h0 && channel_output_disable == 6'h00)
      else $error("reset values");
   a_single_read: assert property (
      (rq && !readback_auto_inc) |=> rd_valid && rd_last)
      else $error("single read");
   a_burst_start: assert property (
      (rq && readback_auto_inc) |=> ctl_busy ##1 rd_valid)
      else $error("burst start");
   a_last_free: assert property (
      rd_last |-> !ctl_busy) else $error("busy past last");
endmodule
bind ad_ctrl ad_chk i_chk (.mclk(mclk), .srst(srst),
   .ctl_valid(ctl_valid), .ctl_word(ctl_word), .ctl_busy(ctl_busy),
   .rd_valid(rd_valid), .rd_last(rd_last),
   .system_clock_output_pin_oe(system_clock_output_pin_oe),
   .amp_from_common_mode(amp_from_common_mode),
   .channel_output_disable(channel_output_disable),
   .clock_out_disable(clock_out_disable),
   .audio_format_select(audio_format_select),
   .readback_auto_inc(readback_auto_inc),
   .readback_index(readback_index));
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic sck_in = 1'b0;
   wire logic ctl_valid, ctl_busy, rd_valid, rd_last, pin_o, pin_oe;
   wire logic flt, half, cdis, dma, dmb, dmc, inc;
   wire logic [15:0] ctl_word, rd_word;
   wire logic [5:0] amp, cod;
   wire logic [2:0] fmt;
   wire logic [1:0] dmf;
   wire logic [6:0] ridx;
   integer err_total = 0;
   integer cmp_count = 0;
   logic [15:0] w;
   always #5 mclk = ~mclk;
   always begin
      repeat (4) @(posedge mclk);
      #1 sck_in = ~sck_in;
   end
   ad_host i_host (.mclk(mclk), .ctl_valid(ctl_valid),
      .ctl_word(ctl_word));
   ad_ctrl i_dut (.mclk(mclk), .srst(srst), .ctl_valid(ctl_valid),
      .ctl_word(ctl_word), .ctl_busy(ctl_busy), .rd_valid(rd_valid),
      .rd_last(rd_last), .rd_word(rd_word),
      .system_clock_input_pin(sck_in),
      .system_clock_output_pin_o(pin_o),
      .system_clock_output_pin_oe(pin_oe), .amp_from_common_mode(amp),
      .channel_output_disable(cod), .filter_rolloff_select(flt),
      .clock_out_half_rate(half), .clock_out_disable(cdis),
      .audio_format_select(fmt), .deemph_rate_select(dmf),
      .deemph_enable_pair_a(dma), .deemph_enable_pair_b(dmb),
      .deemph_enable_pair_c(dmc), .readback_auto_inc(inc),
      .readback_index(ridx));
   // ==========================================================
   // Helpers
   task end_of_test;
      if (err_total == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task rd(input logic [6:0] idx);
      integer n;
      i_host.put({8'h0b, 1'b0, idx});
      i_host.put(16'h8000);
      for (n = 0; n < 4 && rd_valid !== 1'b1; n++) begin
         @(posedge mclk);
         #1;
      end
      w = rd_word;
      if (n == 4) begin
         chk(rd_valid, 1'b1);
         end_of_test;
      end
   endtask
   // ==========================================================
   // Scenarios
   task t_reset;
      chk({inc, ridx}, 8'h01);
      chk({flt, half, cdis, fmt}, 6'h00);
      chk({dmf, dmc, dmb, dma}, 5'h00);
      chk(cod, 6'h00);
   endtask
   task t_regs;
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         d = {2'b11, 3'(i ^ 5), 3'(i)};
         i_host.put({8'h09, d});
         chk({flt, half, cdis, fmt}, d[5:0]);
         rd(7'h09);
         chk(w, {8'h09, 2'b00, d[5:0]});
         chk(pin_oe, !d[3]);
         d = {3'b111, 2'(i % 3), 3'(i)};
         i_host.put({8'h0a, d});
         chk({dmf, dmc, dmb, dma}, d[4:0]);
         rd(7'h0a);
         chk(w, {8'h0a, 3'b000, d[4:0]});
      end
      for (int i = 0; i < 6; i++) begin
         d = 8'hc0 | (8'h01 << i);
         i_host.put({8'h08, d});
         chk(cod, d[5:0]);
         @(posedge mclk);
         #1;
         chk(amp, d[5:0]);
      end
      i_host.put(16'h2055);
      rd(7'h20);
      chk(w, 16'h2000);
   endtask
   task t_clk;
      integer n;
      logic p;
      for (int h = 0; h < 2; h++) begin
         i_host.put({8'h09, 3'b000, 1'(h), 4'h0});
         // Let the pin settle in the new rate before counting
         repeat (2) @(posedge mclk);
         #1;
         n = 0;
         p = pin_o;
         repeat (80) begin
            @(posedge mclk);
            #1;
            if (pin_o && !p) n++;
            p = pin_o;
         end
         chk(h ? (n == 5) : (n == 10), 1'b1);
      end
   endtask
   task t_burst;
      i_host.put(16'h0b83);
      i_host.put(16'h8000);
      chk(ctl_busy, 1'b1);
      // A read offered in mid-burst must be dropped
      fork
         i_host.put(16'h8000);
         for (int k = 1; k < 4; k++) begin
            @(posedge mclk);
            #1;
            chk({rd_valid, rd_last}, {1'b1, k == 3});
            chk(rd_word, {1'b0, 7'(k), 8'h00});
         end
      join
      @(posedge mclk);
      #1;
      chk({rd_valid, ctl_busy}, 2'b00);
      i_host.put(16'h0b80);
      i_host.put(16'h8000);
      @(posedge mclk);
      #1;
      chk({rd_valid, rd_last}, 2'b11);
      chk(rd_word, 16'h0100);
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      #1 srst = 1'b0;
      t_reset;
      t_regs;
      t_clk;
      t_burst;
      i_host.put(16'h0905);
      srst = 1'b1;
      repeat (3) @(posedge mclk);
      #1 srst = 1'b0;
      t_reset;
      end_of_test;
   end
endmodule
`default_nettype wire
